// File: hdl/udr_event_latch.sv
/*
  USB dual-role event latch: live status, edge-enabled sticky latch,
  fall and rise enable registers, AHB-Lite slave.
  Assumes one hclk domain; level sources are asynchronous, pulse sources
  are single-cycle on hclk; only whole-word single transfers.
*/
// The AHB-Lite slave port is this design's own decision.
// Function
// - read-only 16-bit live status at 0x378
// - status bit 0 is bus-power valid
// - status bit 3 is role ident level
// - bit 8 flags 2 ms idle SE0
// - bit 1 is session valid
// - status levels live after reset, others zero
// - latch at set/clear 0x37C/0x37E, resets zero
// - hardware sets latch only on enabled edge direction
// - latch bit 6 on peer drop-reconnect
// - latch bit 3 on enabled ident change
// - latch bit 0 on enabled bus-power change
// - bit 2 shows D+ driven during request
// - fall enable at 0x380/0x382, resets zero
// - fall bit 8 fires on long SE0 exit
// - fall bit 7 fires on session end leaving
// - fall bit 4 fires on remote connect loss
// - fall bit 3 fires on ident falling
// - fall bit 1 fires on session valid loss
// - fall bit 0 fires on bus-power falling
// - rise enable at 0x384/0x386, bits 0-9, for rising edges
// - latch bit 9 on enabled timer expiry
`timescale 1ns/100ps
`default_nettype none
`include "udr_defs.svh"

module udr_event_latch #(
  parameter int SE0_MIN_CYCLES = `UDR_SE0_MIN_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire udr_pkg::udr_lvl_s lvl_in,
  input wire udr_pkg::udr_pulse_s pulse_in,
  output logic event_irq
);
  import udr_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  generate
    if (SE0_MIN_CYCLES < 1)
    begin : g_bad_se0
      $error("SE0_MIN_CYCLES must be at least 1");
    end
  endgenerate

  localparam int CNT_W = $clog2(SE0_MIN_CYCLES + 1);
  localparam logic [CNT_W-1:0] SE0_LIM = CNT_W'(SE0_MIN_CYCLES);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  udr_lvl_s lvl_s1_r;
  udr_lvl_s lvl_s2_r;
  udr_phase_e phase_r;
  udr_phase_e phase_nxt;
  logic [9:0] idx_r;
  logic ok_r;
  logic [31:0] hrdata_r;
  logic [15:0] latch_r;
  logic [15:0] latch_nxt;
  logic [15:0] fall_r;
  logic [15:0] fall_nxt;
  logic [15:0] rise_r;
  logic [15:0] rise_nxt;
  logic [9:0] prev_r;
  logic [2:0] arm_r;
  logic [CNT_W-1:0] se0_cnt_r;
  logic [CNT_W-1:0] se0_cnt_nxt;
  logic irq_r;
  wire logic accept;
  wire logic wr;
  wire logic [15:0] wdat;
  wire logic wr_latch_set;
  wire logic wr_latch_clr;
  wire logic wr_fall_set;
  wire logic wr_fall_clr;
  wire logic wr_rise_set;
  wire logic wr_rise_clr;
  wire logic long_se0;
  wire logic [9:0] cur;
  wire logic [9:0] hw_set;
  wire logic [15:0] status;
  wire logic [15:0] rd_val;

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lvl_s1_r <= '0;
      lvl_s2_r <= '0;
    end
    else
    begin
      lvl_s1_r <= lvl_in;
      lvl_s2_r <= lvl_s1_r;
    end
  end

  // ----------------------------------------------------------------------
  // long SE0 detector
  // ----------------------------------------------------------------------
  // counts only in B-idle; any break in SE0 restarts the count, so the
  // flag falls the cycle after SE0 ends and that fall is the exit event
  assign se0_cnt_nxt = !lvl_s2_r.line_se0 ? '0 :
                       (lvl_s2_r.b_idle && se0_cnt_r != SE0_LIM) ?
                       se0_cnt_r + 1'b1 : se0_cnt_r;
  assign long_se0 = (se0_cnt_r == SE0_LIM);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      se0_cnt_r <= '0;
    else
      se0_cnt_r <= se0_cnt_nxt;
  end

  // ----------------------------------------------------------------------
  // live status
  // ----------------------------------------------------------------------
  // levels come straight from the synchronisers, so after reset they
  // follow the live conditions once two edges have passed
  assign status = {7'h00,
                   long_se0,
                   lvl_s2_r.session_end_flag,
                   2'b00,
                   lvl_s2_r.remote_connect_flag,
                   lvl_s2_r.role_ident_pin,
                   lvl_s2_r.dplus_session_request_flag,
                   lvl_s2_r.session_valid_flag,
                   lvl_s2_r.bus_power_valid_flag};

  // ----------------------------------------------------------------------
  // event sources and edge detection
  // ----------------------------------------------------------------------
  // pulse sources look like one-cycle levels: their rise is the event and
  // their fall enables are not implemented
  assign cur[`UDR_BIT_VBUS] = lvl_s2_r.bus_power_valid_flag;
  assign cur[`UDR_BIT_SESS_VLD] = lvl_s2_r.session_valid_flag;
  assign cur[`UDR_BIT_DPLUS_SESSION_REQUEST_FLAG] = lvl_s2_r.dplus_session_request_flag;
  assign cur[`UDR_BIT_ID] = lvl_s2_r.role_ident_pin;
  assign cur[`UDR_BIT_REMOTE_CONNECT_FLAG] = lvl_s2_r.remote_connect_flag;
  assign cur[`UDR_BIT_RESUME] = pulse_in.jk_resume_flag;
  assign cur[`UDR_BIT_PEER_DROP] = pulse_in.peer_drop_reconnect_event;
  assign cur[`UDR_BIT_SESS_END] = lvl_s2_r.session_end_flag;
  assign cur[`UDR_BIT_LONG_SE0] = long_se0;
  assign cur[`UDR_BIT_TIMER] = pulse_in.role_timer_expired_flag;

  // edges are held off until the synchronisers carry real levels, or the
  // first live high after reset would look like a rising edge
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++)
    begin : g_edge
      assign hw_set[gi] = arm_r[2] &&
        ((cur[gi] && !prev_r[gi] && rise_r[gi]) ||
         (!cur[gi] && prev_r[gi] && fall_r[gi]));
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_r <= '0;
      arm_r <= '0;
    end
    else
    begin
      prev_r <= cur;
      arm_r <= {arm_r[1:0], 1'b1};
    end
  end

  // ----------------------------------------------------------------------
  // AHB-Lite address and data phase
  // ----------------------------------------------------------------------
  assign accept = hsel && hready && htrans[1];

  always_comb
  begin
    if (accept)
      phase_nxt = hwrite ? UDR_PH_WRITE : UDR_PH_READ;
    else if (phase_r == UDR_PH_READ)
      phase_nxt = UDR_PH_RDATA;
    else if (phase_r == UDR_PH_RDATA || phase_r == UDR_PH_WRITE)
      phase_nxt = UDR_PH_IDLE;
    else
      phase_nxt = phase_r;
  end

  // a read waits one cycle so that a write just before it is seen
  assign hreadyout = (phase_r != UDR_PH_READ);
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_r <= UDR_PH_IDLE;
      idx_r <= '0;
      ok_r <= 1'b0;
    end
    else
    begin
      phase_r <= phase_nxt;
      if (accept)
      begin
        idx_r <= haddr[11:2];
        ok_r <= (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'b00);
      end
    end
  end

  // ----------------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------------
  assign wr = (phase_r == UDR_PH_WRITE) && ok_r;
  assign wdat = hwdata[15:0];
  assign wr_latch_set = wr && (idx_r == `UDR_IDX_LATCH_SET);
  assign wr_latch_clr = wr && (idx_r == `UDR_IDX_LATCH_CLR);
  assign wr_fall_set = wr && (idx_r == `UDR_IDX_FALL_SET);
  assign wr_fall_clr = wr && (idx_r == `UDR_IDX_FALL_CLR);
  assign wr_rise_set = wr && (idx_r == `UDR_IDX_RISE_SET);
  assign wr_rise_clr = wr && (idx_r == `UDR_IDX_RISE_CLR);

  // a hardware event in the same cycle as a clear write wins
  assign latch_nxt = (((latch_r | (wr_latch_set ? wdat : 16'h0000)) &
                       ~(wr_latch_clr ? wdat : 16'h0000)) |
                      {6'h00, hw_set}) & `UDR_LATCH_MASK;
  assign fall_nxt = (fall_r | (wr_fall_set ? wdat : 16'h0000)) &
                    ~(wr_fall_clr ? wdat : 16'h0000) &
                    `UDR_FALL_MASK;
  assign rise_nxt = (rise_r | (wr_rise_set ? wdat : 16'h0000)) &
                    ~(wr_rise_clr ? wdat : 16'h0000) &
                    `UDR_RISE_MASK;

  // unmapped and misaligned addresses read zero and ignore writes
  assign rd_val = !ok_r ? 16'h0000 :
    (idx_r == `UDR_IDX_STATUS) ? (status & `UDR_STATUS_MASK) :
    (idx_r == `UDR_IDX_LATCH_SET || idx_r == `UDR_IDX_LATCH_CLR) ?
      latch_r :
    (idx_r == `UDR_IDX_FALL_SET || idx_r == `UDR_IDX_FALL_CLR) ?
      fall_r :
    (idx_r == `UDR_IDX_RISE_SET || idx_r == `UDR_IDX_RISE_CLR) ?
      rise_r : 16'h0000;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      latch_r <= `UDR_LATCH_RST;
      fall_r <= `UDR_FALL_RST;
      rise_r <= `UDR_RISE_RST;
      irq_r <= 1'b0;
      hrdata_r <= '0;
    end
    else
    begin
      latch_r <= latch_nxt;
      fall_r <= fall_nxt;
      rise_r <= rise_nxt;
      irq_r <= |latch_nxt;
      if (phase_r == UDR_PH_READ)
        hrdata_r <= {16'h0000, rd_val};
    end
  end

  // fall bits 0,1,3,4,7,8 act through g_edge on falling source levels:
  // bus power session valid ident
  // remote connect session end leaving and
  // long SE0 ending ident changes land in bit 3
  // bus power changes in bit 0 timer expiry in bit 9
  assign event_irq = irq_r;

endmodule
`default_nettype wire

// File: hdl/udr_defs.svh
/*
  Offsets, field masks, reset values and timing counts of the USB dual-role
  event latch. Assumes a 125 MHz bus clock.
*/
`ifndef UDR_DEFS_SVH
`define UDR_DEFS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define UDR_IDX_STATUS 10'h378
`define UDR_IDX_LATCH_SET 10'h37C
`define UDR_IDX_LATCH_CLR 10'h37E
`define UDR_IDX_FALL_SET 10'h380
`define UDR_IDX_FALL_CLR 10'h382
`define UDR_IDX_RISE_SET 10'h384
`define UDR_IDX_RISE_CLR 10'h386

// ----------------------------------------------------------------------
// implemented bits and reset values
// ----------------------------------------------------------------------
`define UDR_STATUS_MASK 16'h019F
`define UDR_LATCH_MASK 16'h03FF
`define UDR_FALL_MASK 16'h019B
`define UDR_RISE_MASK 16'h03FF
`define UDR_LATCH_RST 16'h0000
`define UDR_FALL_RST 16'h0000
`define UDR_RISE_RST 16'h0000

// ----------------------------------------------------------------------
// event bit positions
// ----------------------------------------------------------------------
`define UDR_BIT_VBUS 0
`define UDR_BIT_SESS_VLD 1
`define UDR_BIT_DPLUS_SESSION_REQUEST_FLAG 2
`define UDR_BIT_ID 3
`define UDR_BIT_REMOTE_CONNECT_FLAG 4
`define UDR_BIT_RESUME 5
`define UDR_BIT_PEER_DROP 6
`define UDR_BIT_SESS_END 7
`define UDR_BIT_LONG_SE0 8
`define UDR_BIT_TIMER 9

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define UDR_CLK_PERIOD_NS 8
`define UDR_SE0_MIN_MS 2
`define UDR_SE0_MIN_CYC \
  ((`UDR_SE0_MIN_MS * 1000000 + `UDR_CLK_PERIOD_NS - 1) / `UDR_CLK_PERIOD_NS)

`endif

// File: hdl/udr_pkg.sv
/*
  Types of the USB dual-role event latch: source bundles and bus phases.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package udr_pkg;

  // levels from pins and comparators, asynchronous to hclk
  typedef struct packed {
    logic session_end_flag;
    logic remote_connect_flag;
    logic role_ident_pin;
    logic dplus_session_request_flag;
    logic session_valid_flag;
    logic bus_power_valid_flag;
    logic line_se0;
    logic b_idle;
  } udr_lvl_s;

  // one-cycle events from logic on hclk
  typedef struct packed {
    logic peer_drop_reconnect_event;
    logic jk_resume_flag;
    logic role_timer_expired_flag;
  } udr_pulse_s;

  typedef enum logic [1:0] {
    UDR_PH_IDLE,
    UDR_PH_WRITE,
    UDR_PH_READ,
    UDR_PH_RDATA
  } udr_phase_e;

endpackage

// File: verification/udr_event_latch_checker.sv
/*
  Checker for the dual-role event latch: bus timing, reserved bits,
  live status and the sticky request.
  Assumes one bus slave, so hready follows hreadyout.
*/
`timescale 1ns/100ps
`default_nettype none

module udr_event_latch_checker #(
  parameter int SE0_MIN_CYCLES = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire udr_pkg::udr_lvl_s lvl_in,
  input wire udr_pkg::udr_pulse_s pulse_in,
  input wire logic event_irq
);
  import udr_pkg::*;
  logic rd_at;
  logic wr_at;
  logic [7:0] st_lvl;
  assign rd_at = hsel & hready & htrans[1] & ~hwrite;
  assign wr_at = hsel & hready & htrans[1] & hwrite;
  assign st_lvl = {lvl_in.session_end_flag, 2'b00, lvl_in.remote_connect_flag,
    lvl_in.role_ident_pin, lvl_in.dplus_session_request_flag,
    lvl_in.session_valid_flag, lvl_in.bus_power_valid_flag};

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_wr_fast;
    wr_at |=> hreadyout;
  endproperty
  a_wr_fast: assert property (p_wr_fast) else $error("write waited");
  property p_rd_wait;
    rd_at |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait");
  property p_hi_zero;
    hrdata[31:16] == 16'h0000;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper data");
  property p_st_rsvd;
    rd_at && haddr == 32'h0DE0 |-> ##2 (hrdata[15:0] & 16'hFE60) == 16'h0;
  endproperty
  a_st_rsvd: assert property (p_st_rsvd) else $error("status rsvd");
  property p_latch_rsvd;
    rd_at && (haddr == 32'h0DF0 || haddr == 32'h0DF8)
      |-> ##2 hrdata[15:10] == 6'h00;
  endproperty
  a_latch_rsvd: assert property (p_latch_rsvd) else $error("latch rsvd");
  property p_fall_rsvd;
    rd_at && (haddr == 32'h0E00 || haddr == 32'h0E08)
      |-> ##2 (hrdata[15:0] & 16'hFE64) == 16'h0;
  endproperty
  a_fall_rsvd: assert property (p_fall_rsvd) else $error("fall rsvd");
  // levels must have settled through the synchronisers before the read
  property p_st_live;
    $stable(lvl_in) [*4] ##0 (rd_at && haddr == 32'h0DE0)
      |-> ##2 hrdata[7:0] == $past(st_lvl, 2);
  endproperty
  a_st_live: assert property (p_st_live) else $error("status level");
  property p_irq_hold;
    event_irq && !$past(wr_at) |=> event_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  c_rd_st: cover property (rd_at && haddr == 32'h0DE0);
  c_irq: cover property ($rose(event_irq));
  c_wr: cover property (wr_at);
endmodule

bind udr_event_latch udr_event_latch_checker #(
  .SE0_MIN_CYCLES(SE0_MIN_CYCLES)
) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .lvl_in(lvl_in), .pulse_in(pulse_in), .event_irq(event_irq)
);
`default_nettype wire

// File: verification/udr_event_latch_test.sv
/*
  Self-checking bench for the dual-role event latch over AHB-Lite.
  Assumes the design package and defines header; one slave on the bus.
*/
`timescale 1ns/100ps
`default_nettype none
`include "udr_defs.svh"

module udr_event_latch_test;
  import udr_pkg::*;
  localparam logic [31:0] A_ST = 32'(`UDR_IDX_STATUS) * 4;
  localparam logic [31:0] A_LS = 32'(`UDR_IDX_LATCH_SET) * 4;
  localparam logic [31:0] A_LC = 32'(`UDR_IDX_LATCH_CLR) * 4;
  localparam logic [31:0] A_FS = 32'(`UDR_IDX_FALL_SET) * 4;
  localparam logic [31:0] A_FC = 32'(`UDR_IDX_FALL_CLR) * 4;
  localparam logic [31:0] A_RS = 32'(`UDR_IDX_RISE_SET) * 4;
  localparam logic [31:0] A_RC = 32'(`UDR_IDX_RISE_CLR) * 4;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  udr_lvl_s lvl_in = '0;
  udr_pulse_s pulse_in = '0;
  logic hreadyout;
  logic hresp;
  logic event_irq;
  logic [31:0] hrdata;
  wire hready;
  int failures = 0;
  int num_checks = 0;
  logic [7:0] lv [3] = '{8'hFC, 8'hA4, 8'h00};
  logic [31:0] ex [3] = '{32'h9F, 32'h89, 32'h0};
  int fb [6] = '{0, 1, 2, 3, 4, 7};
  int li [6] = '{2, 3, 4, 5, 6, 7};
  int pb [3] = '{9, 5, 6};
  assign hready = hreadyout;

  udr_event_latch #(.SE0_MIN_CYCLES(20)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .lvl_in(lvl_in), .pulse_in(pulse_in),
    .event_irq(event_irq)
  );

  always #4 hclk = ~hclk;

  // ------------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // entered just after a rising edge; waits on the slave, never a count
  task automatic bus(input logic [31:0] a, input logic w,
    input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(a, 1'b1, {16'h0, d}, q);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic irqc(input logic [31:0] exp);
    @(posedge hclk);
    chk(32'(event_irq), exp);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge hclk);
    failures++;
    tally_and_finish();
  end

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    rdc(A_LS, 32'h0);
    rdc(A_FS, 32'h0);
    rdc(A_RC, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      lvl_in <= lv[i];
      repeat (4) @(posedge hclk);
      rdc(A_ST, ex[i]);
    end
    wr(A_ST, 16'hFFFF);
    rdc(A_ST, 32'h0);
    wr(A_LS, 16'h03FF);
    irqc(32'h1);
    rdc(A_LC, 32'h3FF);
    wr(A_LC, 16'h0005);
    rdc(A_LS, 32'h3FA);
    wr(A_LC, 16'h03FF);
    irqc(32'h0);
    wr(A_FS, 16'h019B);
    rdc(A_FC, 32'h19B);
    rdc(32'h0F00, 32'h0);
    wr(A_FC, 16'h019B);
    // rise then fall on each level source, rise enables one at a time, fall enables all at once
    for (int i = 0; i < 6; i++)
    begin
      wr(A_RS, 16'(1 << fb[i]));
      lvl_in[li[i]] <= 1'b1;
      repeat (4) @(posedge hclk);
      rdc(A_LS, 32'(1 << fb[i]));
      wr(A_LC, 16'h03FF);
      wr(A_RC, 16'h03FF);
      wr(A_FS, 16'h019B);
      lvl_in[li[i]] <= 1'b0;
      repeat (4) @(posedge hclk);
      rdc(A_LS, 32'(16'h019B & (16'h1 << fb[i])));
      wr(A_LC, 16'h03FF);
      wr(A_FC, 16'h019B);
    end
    for (int j = 0; j < 3; j++)
    begin
      wr(A_RS, 16'(1 << pb[j]));
      pulse_in[j] <= 1'b1;
      @(posedge hclk);
      pulse_in[j] <= 1'b0;
      rdc(A_LS, 32'(1 << pb[j]));
      wr(A_LC, 16'h03FF);
      wr(A_RC, 16'h03FF);
    end
    wr(A_RS, 16'h0100);
    lvl_in <= 8'h03;
    repeat (30) @(posedge hclk);
    rdc(A_ST, 32'h100);
    rdc(A_LS, 32'h100);
    wr(A_LC, 16'h03FF);
    wr(A_RC, 16'h03FF);
    wr(A_FS, 16'h0100);
    lvl_in <= 8'h00;
    repeat (4) @(posedge hclk);
    rdc(A_LS, 32'h100);
    tally_and_finish();
  end
endmodule
`default_nettype wire
